// [design/reading_memory_buffer.sv]
`timescale 1ns/1ps
// Contract
// [R1] Mode off stops storing, keeps contents.
// [R2] LIFO or FIFO select empties memory first.
// [R3] Continue keeps contents, restores previous ordering.
// [R4] High-speed FIFO full forces arm hold.
// [R5] Controller drains then changes arm selection.
// [R6] Normal FIFO full discards new readings.
// [R7] LIFO full overwrites oldest readings.
// [R8] Implied read pops one reading when buffer empty.
// [R9] LIFO returns newest, FIFO returns oldest.
// [R10] Bulk recall order ignores ordering mode.
// [R11] Bulk recall switches storage off.
// [R12] Encoding select empties memory.
// [R13] Text: fifteen characters plus null byte.
// [R14] Encoding 2: 16-bit two's complement.
// [R15] Encoding 3: 32-bit two's complement.
// [R16] Encoding 4: IEEE single, four bytes.
// [R17] Encoding 5: IEEE double, eight bytes.
// [R18] Overload stored as plus/minus 1E+38; code stores integer overloads as 7fff/8000 and 7fffffff/80000000.
// [R19] Overload recalled as output-encoding overload code.
// [R20] Integer recall multiplied by scale factor.
// [R21] Storage encoding leaves output encoding alone.
// [R22] Subsampled arm errors unless int16, FIFO, empty.
// [R23] Count query gives readings held.
// [R24] Mode and encoding queries give current codes.
// [R25] Reset: mode off, single real encoding.
// [R26] Count tracked against capacity; full flag.
module reading_memory_buffer #(
	parameter int MEM_BYTES = reading_memory_pkg::MEM_BYTES,
	parameter int SLOTS     = reading_memory_pkg::SLOTS,
	parameter int OUT_DEPTH = reading_memory_pkg::OUT_DEPTH
) (
	input  wire logic                                sys_clk,
	input  wire logic                                nrst,
	input  wire logic                                mode_wr,
	input  wire reading_memory_pkg::mem_mode_type    mode_code,
	input  wire logic                                storage_encoding_select,
	input  wire reading_memory_pkg::enc_type         enc_code,
	input  wire logic                                bulk_recall,
	input  wire logic                                high_speed,
	input  wire logic                                arm_event_select,
	input  wire logic                                arm_event,
	input  wire logic                                subsampled_measure,
	input  wire reading_memory_pkg::enc_type         output_encoding_select,
	input  wire logic signed [31:0]                  scale_factor,
	input  wire logic                                rdg_valid,
	output wire logic                                rdg_ready,
	input  wire reading_memory_pkg::reading_in_type  rdg,
	input  wire logic                                read_request,
	output wire logic                                out_valid,
	input  wire logic                                out_ready,
	output wire reading_memory_pkg::recall_word_type out_word,
	output wire reading_memory_pkg::mem_mode_type    mode_now,
	output wire reading_memory_pkg::enc_type         enc_now,
	output wire logic [$clog2(SLOTS+1)-1:0]          stored_count_query,
	output wire logic                                mem_full,
	output wire logic                                arm_hold,
	output wire logic                                subsample_error,
	output wire logic                                bulk_busy
);
	import reading_memory_pkg::*;

	localparam int AW = $clog2(SLOTS);
	localparam int CW = $clog2(SLOTS+1);

	// ==========================================================================
	// State
	// ==========================================================================
	mem_entry_type     mem_q [SLOTS];
	mem_mode_type      mode_q;
	mem_mode_type      prev_q;
	enc_type           enc_q;
	recall_state_type  state_q;
	logic [AW-1:0]     rd_ptr_q;
	logic [AW-1:0]     wr_ptr_q;
	logic [CW-1:0]     count_q;
	logic [CW-1:0]     bulk_idx_q;
	logic              hold_q;
	logic              sub_err_q;

	function automatic logic [CW-1:0] cap_of(input enc_type enc);
		int n;
		n = MEM_BYTES / bytes_per(enc);
		cap_of = (n > SLOTS) ? CW'(SLOTS) : CW'(n);
	endfunction : cap_of

	// ==========================================================================
	// Decode
	// ==========================================================================
	wire            idle       = state_q == RS_IDLE;
	wire            cmd_mode   = mode_wr && idle;
	wire            cmd_enc    = storage_encoding_select && idle;
	wire            sel_order  = cmd_mode && (mode_code == MODE_LIFO || mode_code == MODE_FIFO);
	wire            clear_now  = sel_order || cmd_enc;
	wire            ordering   = mode_q == MODE_LIFO || mode_q == MODE_FIFO;
	wire [CW-1:0]   cap        = cap_of(enc_q);
	wire            full       = count_q >= cap; // [R26]
	wire            pop_now    = read_request && idle && !out_valid && ordering && count_q != '0
		&& !cmd_mode && !cmd_enc; // [R8]
	wire            bulk_start = bulk_recall && idle && !cmd_mode && !cmd_enc;
	wire            bulk_push;
	wire            fifo_ready;
	wire            store_take = rdg_valid && rdg_ready && ordering && !hold_q; // [R1]
	wire            lifo_wrap  = store_take && full && mode_q == MODE_LIFO;
	wire            write_en   = store_take && (!full || mode_q == MODE_LIFO); // [R6] [R7]
	wire            hold_set   = high_speed && mode_q == MODE_FIFO && full; // [R4]
	wire            sub_bad    = !(enc_q == ENC_INT16 && mode_q == MODE_FIFO && count_q == '0);
	wire            sub_fire   = arm_event && subsampled_measure && sub_bad; // [R22]
	wire            bulk_last  = bulk_push && (bulk_idx_q + 1'b1 == count_q);
	wire mem_mode_type resume_previous_mode_mode = (prev_q == MODE_OFF) ? MODE_FIFO : prev_q; // [R3]

	assign rdg_ready = !pop_now && !clear_now && idle;
	assign bulk_push = !idle && fifo_ready;

	// ==========================================================================
	// Read selection and recall conversion
	// ==========================================================================
	// Bulk recall always walks oldest to newest, so ordering mode never matters there.
	wire [AW-1:0]   bulk_idx   = rd_ptr_q + bulk_idx_q[AW-1:0]; // [R10]
	wire [AW-1:0]   newest_idx = wr_ptr_q - 1'b1;
	wire [AW-1:0]   rd_idx     = !idle ? bulk_idx
		: (mode_q == MODE_LIFO) ? newest_idx : rd_ptr_q; // [R9]
	mem_entry_type  rd_entry;
	assign rd_entry = mem_q[rd_idx];

	wire logic signed [63:0] int_val = (enc_q == ENC_INT16)
		? 64'(signed'(rd_entry.data[15:0])) : 64'(signed'(rd_entry.data[31:0]));
	wire logic signed [63:0] scaled  = 64'(int_val * 64'(scale_factor)); // [R20]
	wire             is_int  = enc_q == ENC_INT16 || enc_q == ENC_INT32;
	recall_word_type recall;
	// Overloads take the output encoding's code; plain readings keep storage form, except integers, which are scaled by scale_factor.
	assign recall.overload = rd_entry.overload;
	assign recall.enc  = rd_entry.overload ? output_encoding_select : enc_q; // [R21]
	assign recall.data = rd_entry.overload
		? overload_word(output_encoding_select, rd_entry.negative) // [R19]
		: is_int ? {64'h0, scaled} : rd_entry.data;

	reading_out_fifo #(
		.WIDTH($bits(recall_word_type)),
		.DEPTH(OUT_DEPTH)
	) u_out_fifo (
		.sys_clk  (sys_clk),
		.nrst     (nrst),
		.in_valid (pop_now || !idle),
		.in_ready (fifo_ready),
		.in_data  (recall),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_data (out_word)
	);

	// ==========================================================================
	// Mode, encoding and recall sequencing
	// ==========================================================================
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			mode_q     <= MODE_RESET; // [R25]
			prev_q     <= MODE_OFF;
			enc_q      <= ENC_RESET;
			state_q    <= RS_IDLE;
			bulk_idx_q <= '0;
		end else begin
			if (cmd_mode) begin
				if (mode_code == MODE_RESUME_PREVIOUS_MODE) begin
					mode_q <= resume_previous_mode_mode; // [R3]
					prev_q <= resume_previous_mode_mode;
				end else begin
					mode_q <= mode_code; // [R1] [R2]
					if (mode_code != MODE_OFF) prev_q <= mode_code;
				end
			end else if (bulk_start) begin
				mode_q <= MODE_OFF; // [R11]
			end
			if (cmd_enc) enc_q <= enc_code; // [R12]
			if (bulk_start && count_q != '0) state_q <= RS_BULK;
			else if (bulk_last) state_q <= RS_IDLE;
			if (bulk_start || bulk_last) bulk_idx_q <= '0;
			else if (bulk_push) bulk_idx_q <= bulk_idx_q + 1'b1;
		end
	end

	// ==========================================================================
	// Reading memory pointers
	// ==========================================================================
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			rd_ptr_q <= '0;
			wr_ptr_q <= '0;
			count_q  <= '0;
		end else if (clear_now) begin
			rd_ptr_q <= '0; // [R2] [R12]
			wr_ptr_q <= '0;
			count_q  <= '0;
		end else if (pop_now) begin
			if (mode_q == MODE_LIFO) wr_ptr_q <= newest_idx; // [R9]
			else rd_ptr_q <= rd_ptr_q + 1'b1;
			count_q <= count_q - 1'b1; // [R8]
		end else if (write_en) begin
			wr_ptr_q <= wr_ptr_q + 1'b1;
			if (lifo_wrap) rd_ptr_q <= rd_ptr_q + 1'b1; // [R7]
			else count_q <= count_q + 1'b1;
		end
	end

	// Storage slots carry no reset; only the pointers define what is held.
	always_ff @(posedge sys_clk) begin
		if (write_en) mem_q[wr_ptr_q] <= encode_entry(enc_q, rdg); // [R13] [R14] [R15] [R16] [R17] [R18]
	end

	// ==========================================================================
	// Arm hold and subsample error
	// ==========================================================================
	// The hold re-arms at once if memory is still full, so the controller must drain first.
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			hold_q    <= 1'b0;
			sub_err_q <= 1'b0;
		end else begin
			if (hold_set) hold_q <= 1'b1; // [R4]
			else if (arm_event_select) hold_q <= 1'b0; // [R5]
			sub_err_q <= sub_fire; // [R22]
		end
	end

	assign mode_now           = mode_q; // [R24]
	assign enc_now            = enc_q;
	assign stored_count_query = count_q; // [R23]
	assign mem_full           = full;
	assign arm_hold           = hold_q;
	assign subsample_error    = sub_err_q;
	assign bulk_busy          = !idle;

	// ==========================================================================
	// Checks
	// ==========================================================================
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	chk_off_keeps: assert property ( // [R1]
		mode_q == MODE_OFF && !cmd_mode && !cmd_enc && !pop_now |=> count_q == $past(count_q)
	) else $error("Memory changed while storage off");

	chk_select_clears: assert property ( // [R2]
		sel_order |=> count_q == '0 && mode_q == $past(mode_code)
	) else $error("Ordering select did not empty memory");

	chk_resume_previous_mode_restore: assert property ( // [R3]
		cmd_mode && mode_code == MODE_RESUME_PREVIOUS_MODE
			|=> count_q == $past(count_q) && mode_q != MODE_OFF && mode_q != MODE_RESUME_PREVIOUS_MODE
	) else $error("Continue lost contents or mode");

	chk_hold_full: assert property ( // [R4]
		hold_set |=> hold_q
	) else $error("Full high-speed FIFO did not hold arm");

	chk_fifo_discard: assert property ( // [R6]
		store_take && full && mode_q == MODE_FIFO && !high_speed
			|=> count_q == $past(count_q) && wr_ptr_q == $past(wr_ptr_q)
	) else $error("Full FIFO accepted a reading");

	chk_lifo_wrap: assert property ( // [R7]
		lifo_wrap && !clear_now |=> count_q == $past(count_q) && rd_ptr_q == $past(rd_ptr_q) + 1'b1
	) else $error("LIFO wrap did not drop oldest");

	chk_implied_pop: assert property ( // [R8]
		pop_now |=> count_q == $past(count_q) - 1'b1 && out_valid
	) else $error("Implied read did not pop one reading");

	chk_bulk_off: assert property ( // [R11]
		bulk_start |=> mode_q == MODE_OFF ##[0:300] idle
	) else $error("Bulk recall left storage on");

	chk_enc_clears: assert property ( // [R12]
		cmd_enc |=> count_q == '0 && enc_q == $past(enc_code)
	) else $error("Encoding select did not empty memory");

	chk_sub_error: assert property ( // [R22]
		arm_event && subsampled_measure && enc_q == ENC_INT16 && mode_q == MODE_FIFO
			&& count_q == '0 |=> !subsample_error
	) else $error("Subsample error raised wrongly");

	chk_reset_mode: assert property ( // [R25]
		$rose(nrst) |-> mode_q == MODE_OFF && enc_q == ENC_REAL32
	) else $error("Reset values wrong");

	chk_count_cap: assert property ( // [R26]
		count_q <= cap
	) else $error("Count exceeds capacity");

	cov_lifo_wrap:   cover property (lifo_wrap);
	cov_bulk_done:   cover property (bulk_start ##[1:40] bulk_last);
	cov_implied_rd:  cover property (pop_now ##1 out_valid && out_ready);
	cov_hold_resume: cover property (hold_q ##[1:40] !hold_q);
endmodule : reading_memory_buffer

// [design/reading_memory_pkg.sv]
package reading_memory_pkg;

	// ==========================================================================
	// Storage mode and encoding codes
	// ==========================================================================
	typedef enum logic [1:0] {
		MODE_OFF  = 2'h0,
		MODE_LIFO = 2'h1,
		MODE_FIFO = 2'h2,
		MODE_RESUME_PREVIOUS_MODE = 2'h3
	} mem_mode_type;

	typedef enum logic [2:0] {
		ENC_NONE   = 3'h0,
		ENC_ASCII  = 3'h1,
		ENC_INT16  = 3'h2,
		ENC_INT32  = 3'h3,
		ENC_REAL32 = 3'h4,
		ENC_REAL64 = 3'h5
	} enc_type;

	typedef enum logic {
		RS_IDLE = 1'b0,
		RS_BULK = 1'b1
	} recall_state_type;

	localparam mem_mode_type MODE_RESET = MODE_OFF;
	localparam enc_type      ENC_RESET  = ENC_REAL32;

	// ==========================================================================
	// Sizes and overload values
	// ==========================================================================
	localparam int DATA_W       = 128;
	localparam int ASCII_CHARS  = 15;
	localparam int BYTES_ASCII  = 16;
	localparam int BYTES_INT16  = 2;
	localparam int BYTES_INT32  = 4;
	localparam int BYTES_REAL32 = 4;
	localparam int BYTES_REAL64 = 8;
	localparam int MEM_BYTES    = 1024;
	localparam int SLOTS        = 256;
	localparam int OUT_DEPTH    = 32;

	localparam logic [119:0] OVL_ASCII_POS  = "  +1.000000E+38";
	localparam logic [119:0] OVL_ASCII_NEG  = "  -1.000000E+38";
	localparam logic [15:0]  OVL_INT16_POS  = 16'h7fff;
	localparam logic [15:0]  OVL_INT16_NEG  = 16'h8000;
	localparam logic [31:0]  OVL_INT32_POS  = 32'h7fffffff;
	localparam logic [31:0]  OVL_INT32_NEG  = 32'h80000000;
	localparam logic [31:0]  OVL_REAL32_POS = 32'h7e967699;
	localparam logic [31:0]  OVL_REAL32_NEG = 32'hfe967699;
	localparam logic [63:0]  OVL_REAL64_POS = 64'h47d2ced32a16a1b1;
	localparam logic [63:0]  OVL_REAL64_NEG = 64'hc7d2ced32a16a1b1;

	// ==========================================================================
	// Carriers
	// ==========================================================================
	typedef struct packed {
		logic              overload;
		logic              negative;
		logic [DATA_W-1:0] value;
	} reading_in_type;

	typedef struct packed {
		logic              overload;
		logic              negative;
		logic [DATA_W-1:0] data;
	} mem_entry_type;

	typedef struct packed {
		logic              overload;
		enc_type           enc;
		logic [DATA_W-1:0] data;
	} recall_word_type;

	// ==========================================================================
	// Helpers
	// ==========================================================================
	function automatic int bytes_per(input enc_type enc);
		unique case (enc)
			ENC_ASCII: bytes_per = BYTES_ASCII;
			ENC_INT16: bytes_per = BYTES_INT16;
			ENC_INT32: bytes_per = BYTES_INT32;
			ENC_REAL64: bytes_per = BYTES_REAL64;
			default: bytes_per = BYTES_REAL32;
		endcase
	endfunction : bytes_per

	function automatic logic [DATA_W-1:0] overload_word(input enc_type enc, input logic neg);
		unique case (enc)
			ENC_ASCII: overload_word = {neg ? OVL_ASCII_NEG : OVL_ASCII_POS, 8'h00};
			ENC_INT16: overload_word = {112'h0, neg ? OVL_INT16_NEG : OVL_INT16_POS};
			ENC_INT32: overload_word = {96'h0, neg ? OVL_INT32_NEG : OVL_INT32_POS};
			ENC_REAL64: overload_word = {64'h0, neg ? OVL_REAL64_NEG : OVL_REAL64_POS};
			default: overload_word = {96'h0, neg ? OVL_REAL32_NEG : OVL_REAL32_POS};
		endcase
	endfunction : overload_word

	// Masks the engine's value down to the width that the encoding keeps.
	function automatic mem_entry_type encode_entry(input enc_type enc, input reading_in_type r);
		encode_entry.overload = r.overload;
		encode_entry.negative = r.negative;
		if (r.overload) begin
			encode_entry.data = overload_word(enc, r.negative);
		end else begin
			unique case (enc)
				ENC_ASCII: encode_entry.data = {r.value[DATA_W-1:8], 8'h00};
				ENC_INT16: encode_entry.data = {112'h0, r.value[15:0]};
				ENC_INT32: encode_entry.data = {96'h0, r.value[31:0]};
				ENC_REAL64: encode_entry.data = {64'h0, r.value[63:0]};
				default: encode_entry.data = {96'h0, r.value[31:0]};
			endcase
		end
	endfunction : encode_entry

endpackage : reading_memory_pkg

// [design/reading_out_fifo.sv]
`timescale 1ns/1ps
module reading_out_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  wire logic             sys_clk,
	input  wire logic             nrst,
	input  wire logic             in_valid,
	output wire logic             in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output wire logic             out_valid,
	input  wire logic             out_ready,
	output wire logic [WIDTH-1:0] out_data
);
	localparam int            AW       = $clog2(DEPTH);
	localparam logic [AW:0]   FULL_CNT = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wp_q;
	logic [AW-1:0]    rp_q;
	logic [AW:0]      cnt_q;
	wire              push = in_valid && in_ready;
	wire              pop  = out_valid && out_ready;

	assign in_ready  = cnt_q != FULL_CNT;
	assign out_valid = cnt_q != '0;
	assign out_data  = mem_q[rp_q];

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) wp_q <= wp_q + 1'b1;
			if (pop) rp_q <= rp_q + 1'b1;
			if (push && !pop) cnt_q <= cnt_q + 1'b1;
			else if (pop && !push) cnt_q <= cnt_q - 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (push) mem_q[wp_q] <= in_data;
	end
endmodule : reading_out_fifo

// [tb/reading_controller_model.sv]
`timescale 1ns/1ps
// ==========================================================================
// Controller side: asks for readings and takes words from the output buffer
// ==========================================================================
module reading_controller_model (
	input  wire logic                                sys_clk,
	input  wire logic                                nrst,
	input  wire logic                                ask,
	input  wire logic                                stall,
	output wire logic                                read_request,
	input  wire logic                                out_valid,
	output wire logic                                out_ready,
	input  wire reading_memory_pkg::recall_word_type out_word
);
	import reading_memory_pkg::*;

	recall_word_type got_q[$];

	// A controller only asks for data while the output buffer is empty.
	assign read_request = ask & ~out_valid;
	// Stalling lets the output buffer fill up and refuse during a bulk recall.
	assign out_ready    = ~stall;

	always @(posedge sys_clk) begin
		if (nrst && out_valid && out_ready) begin
			got_q.push_back(out_word);
		end
	end
endmodule : reading_controller_model

// [tb/reading_memory_buffer_test.sv]
`timescale 1ns/1ps
module reading_memory_buffer_test;
	import reading_memory_pkg::*;

	localparam int SL = 64;
	localparam int CW = $clog2(SL + 1);
	localparam logic [127:0] LO = {64'h0, {64{1'b1}}};

	typedef struct {
		enc_type      enc;
		enc_type      oenc;
		logic         ovl;
		logic         neg;
		logic [127:0] val;
		logic [127:0] exp;
		logic [127:0] mask;
	} row_type;

	logic            sys_clk, nrst, mode_wr, storage_encoding_select, bulk_recall;
	logic            high_speed, arm_event_select, arm_event, subsampled_measure;
	logic            rdg_valid, rdg_ready, read_request, out_valid, out_ready, ask, stall;
	logic            mem_full, arm_hold, subsample_error, bulk_busy;
	mem_mode_type    mode_code, mode_now;
	enc_type         enc_code, output_encoding_select, enc_now;
	reading_in_type  rdg;
	recall_word_type out_word, w;
	logic [CW-1:0]   stored_count_query;
	int              fails, checked, cycles, n;
	row_type         rows[7];

	reading_memory_buffer #(.MEM_BYTES(256), .SLOTS(SL), .OUT_DEPTH(32)) dut (
		.sys_clk(sys_clk), .nrst(nrst), .mode_wr(mode_wr), .mode_code(mode_code),
		.storage_encoding_select(storage_encoding_select), .enc_code(enc_code),
		.bulk_recall(bulk_recall), .high_speed(high_speed),
		.arm_event_select(arm_event_select), .arm_event(arm_event),
		.subsampled_measure(subsampled_measure),
		.output_encoding_select(output_encoding_select), .scale_factor(32'sd3),
		.rdg_valid(rdg_valid), .rdg_ready(rdg_ready), .rdg(rdg),
		.read_request(read_request), .out_valid(out_valid), .out_ready(out_ready),
		.out_word(out_word), .mode_now(mode_now), .enc_now(enc_now),
		.stored_count_query(stored_count_query), .mem_full(mem_full),
		.arm_hold(arm_hold), .subsample_error(subsample_error), .bulk_busy(bulk_busy));

	reading_controller_model ctl (
		.sys_clk(sys_clk), .nrst(nrst), .ask(ask), .stall(stall),
		.read_request(read_request), .out_valid(out_valid), .out_ready(out_ready),
		.out_word(out_word));

	// ==========================================================================
	// Clock, timeout and shared tasks
	// ==========================================================================
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("Checks %0d, mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input string name, input logic [127:0] e, input logic [127:0] g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", name, e, g);
		end
	endtask : chk

	task automatic cmd(input logic m, input mem_mode_type mc, input logic e, input enc_type ec);
		@(negedge sys_clk);
		mode_wr = m;
		mode_code = mc;
		storage_encoding_select = e;
		enc_code = ec;
		@(negedge sys_clk);
		mode_wr = 1'b0;
		storage_encoding_select = 1'b0;
	endtask : cmd

	task automatic store(input logic [127:0] v, input logic ovl, input logic neg);
		@(negedge sys_clk);
		rdg_valid = 1'b1;
		rdg = '{ovl, neg, v};
		@(negedge sys_clk);
		rdg_valid = 1'b0;
	endtask : store

	task automatic pulse(ref logic s);
		@(negedge sys_clk);
		s = 1'b1;
		@(negedge sys_clk);
		s = 1'b0;
	endtask : pulse

	task automatic pop_chk(input logic [127:0] e, input logic [127:0] m, input enc_type xe,
			input logic xo);
		pulse(ask);
		n = 0;
		while (ctl.got_q.size() == 0 && n < 20) begin
			@(negedge sys_clk);
			n++;
		end
		w = (ctl.got_q.size() > 0) ? ctl.got_q.pop_front() : '0;
		chk("out_data", e & m, w.data & m);
		chk("out_enc", {125'h0, xe}, {125'h0, w.enc});
		chk("out_overload", {127'h0, xo}, {127'h0, w.overload});
	endtask : pop_chk

	// ==========================================================================
	// Main sequence
	// ==========================================================================
	initial begin
		{mode_wr, storage_encoding_select, bulk_recall, high_speed, arm_event_select} = '0;
		{arm_event, subsampled_measure, rdg_valid, ask, stall} = '0;
		{fails, checked, cycles} = '0;
		mode_code = MODE_OFF;
		enc_code = ENC_REAL32;
		output_encoding_select = ENC_REAL32;
		rdg = '0;
		nrst = 1'b0;
		rows[0] = '{ENC_ASCII, ENC_REAL32, 0, 0, {"  +1.234567E+00", 8'h55},
			{"  +1.234567E+00", 8'h00}, '1};
		rows[1] = '{ENC_INT16, ENC_REAL32, 0, 0, 128'h1234fffe, 128'hfffffffffffffffa, LO};
		rows[2] = '{ENC_INT32, ENC_REAL32, 0, 0, 128'hab00000010, 128'h30, LO};
		rows[3] = '{ENC_REAL32, ENC_REAL32, 0, 0, 128'hdead3f800000, 128'h3f800000, LO};
		rows[4] = '{ENC_REAL64, ENC_REAL32, 0, 0, 128'h7744000000000000001,
			128'h4000000000000001, LO};
		rows[5] = '{ENC_REAL32, ENC_INT16, 1, 0, 128'h0, {112'h0, OVL_INT16_POS}, LO};
		rows[6] = '{ENC_ASCII, ENC_REAL64, 1, 1, 128'h0, {64'h0, OVL_REAL64_NEG}, LO};
		repeat (8) @(negedge sys_clk);
		nrst = 1'b1;
		chk("mode_now", MODE_OFF, mode_now);
		chk("enc_now", ENC_REAL32, enc_now);
		chk("count", 0, stored_count_query);
		cmd(1, MODE_RESUME_PREVIOUS_MODE, 0, ENC_REAL32);
		chk("mode_now", MODE_FIFO, mode_now);
		foreach (rows[i]) begin
			output_encoding_select = rows[i].oenc;
			store(128'h5, 0, 0);
			cmd(0, MODE_OFF, 1, rows[i].enc);
			chk("enc_now", rows[i].enc, enc_now);
			chk("count", 0, stored_count_query);
			cmd(1, MODE_FIFO, 0, ENC_REAL32);
			store(rows[i].val, rows[i].ovl, rows[i].neg);
			chk("count", 1, stored_count_query);
			pop_chk(rows[i].exp, rows[i].mask, rows[i].ovl ? rows[i].oenc : rows[i].enc,
				rows[i].ovl);
		end
		// A full FIFO memory outside high speed keeps the oldest readings.
		cmd(1, MODE_FIFO, 1, ENC_REAL32);
		for (int i = 0; i <= SL; i++) store(i, 0, 0);
		chk("count", SL, stored_count_query);
		chk("mem_full", 1, mem_full);
		pop_chk(0, LO, ENC_REAL32, 0);
		pop_chk(1, LO, ENC_REAL32, 0);
		cmd(1, MODE_OFF, 0, ENC_REAL32);
		store(128'h99, 0, 0);
		chk("count", SL - 2, stored_count_query);
		cmd(1, MODE_RESUME_PREVIOUS_MODE, 0, ENC_REAL32);
		chk("mode_now", MODE_FIFO, mode_now);
		pop_chk(2, LO, ENC_REAL32, 0);
		// LIFO wraps over the oldest; bulk recall then stalls on the output buffer.
		cmd(1, MODE_LIFO, 0, ENC_REAL32);
		chk("count", 0, stored_count_query);
		for (int i = 0; i < SL + 2; i++) store(500 + i, 0, 0);
		chk("count", SL, stored_count_query);
		pop_chk(501 + SL, LO, ENC_REAL32, 0);
		stall = 1'b1;
		pulse(bulk_recall);
		chk("mode_now", MODE_OFF, mode_now);
		repeat (40) @(negedge sys_clk);
		chk("bulk_busy", 1, bulk_busy);
		chk("taken", 0, ctl.got_q.size());
		chk("rdg_ready", 0, rdg_ready);
		stall = 1'b0;
		n = 0;
		while ((bulk_busy || out_valid) && n < 200) begin
			@(negedge sys_clk);
			n++;
		end
		repeat (3) @(negedge sys_clk);
		chk("taken", SL - 1, ctl.got_q.size());
		chk("first", 502, ctl.got_q[0].data);
		chk("last", 500 + SL, ctl.got_q[SL - 2].data);
		ctl.got_q.delete();
		// High-speed FIFO full forces the arm hold until drained and re-armed.
		cmd(1, MODE_FIFO, 0, ENC_REAL32);
		high_speed = 1'b1;
		for (int i = 0; i < SL; i++) store(i, 0, 0);
		repeat (2) @(negedge sys_clk);
		chk("arm_hold", 1, arm_hold);
		pulse(arm_event_select);
		chk("arm_hold", 1, arm_hold);
		high_speed = 1'b0;
		pop_chk(0, LO, ENC_REAL32, 0);
		pulse(arm_event_select);
		repeat (2) @(negedge sys_clk);
		chk("arm_hold", 0, arm_hold);
		// Sub-sampled arming needs int16, FIFO and an empty memory.
		subsampled_measure = 1'b1;
		pulse(arm_event);
		chk("subsample_error", 1, subsample_error);
		cmd(1, MODE_FIFO, 1, ENC_INT16);
		pulse(arm_event);
		chk("subsample_error", 0, subsample_error);
		report_and_stop();
	end
endmodule : reading_memory_buffer_test
